// File: rtl/asr_interval_shutdown.v
// apb register bank holding adc sampling intervals, sample ticks and the shutdown cause record
`timescale 1ns/1ps
`default_nettype none
`include "asr_regs.vh"

//
// Contract
// - cell conversions use the interval code in cell register bits 7:4.
// - die temperature conversions use the interval code in cell register bits 3:0.
// - codes map monotonically from 4.13 us to 1000 us; codes 0-3 discouraged.
// - aux register holds eight codes, input 0 on top, input 7 at bottom.
// - module monitor conversions use test register bits 15:12.
// - analog reference conversions use test register bits 7:4.
// - negative rail conversions use test register bits 3:0.
// - controller flag sets on power-down write or communication power-down timeout.
// - digital thermal flag sets on digital over-temperature or io supply held low.
// - always-on flag sets when that falling supply reaches its reset threshold.
// - analog flag sets when the analog die requests shutdown.
// - regulator timeout flag sets when the regulated supply came up too slowly.
// - analog thermal flag in bit zero sets on analog die thermal shutdown.
module asr_interval_shutdown #(
  parameter NCH = 13
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [3:0] pstrb,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  output wire irq,
  input wire comm_pd_timeout,
  input wire digital_tsd,
  input wire io_supply_held_low,
  input wire always_on_supply_por,
  input wire analog_pd_req,
  input wire regulator_timeout,
  input wire analog_tsd,
  output wire power_down_request,
  output wire [3:0] cell_interval_code,
  output wire [3:0] die_temp_interval_code,
  output wire [3:0] sensor_input0_interval,
  output wire [3:0] sensor_input1_interval,
  output wire [3:0] sensor_input2_interval,
  output wire [3:0] sensor_input3_interval,
  output wire [3:0] sensor_input4_interval,
  output wire [3:0] sensor_input5_interval,
  output wire [3:0] sensor_input6_interval,
  output wire [3:0] sensor_input7_interval,
  output wire [3:0] module_monitor_interval,
  output wire [3:0] analog_ref_interval,
  output wire [3:0] negative_rail_interval,
  output wire [7:0] shutdown_cause,
  output wire [NCH-1:0] sample_tick
);

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------

  // merge write data into a register under the byte strobes
  // a lane whose strobe is low keeps its old byte
  function [31:0] asr_merge;
    input [31:0] old;
    input [31:0] wd;
    input [3:0] strb;
    integer b;
    begin
      asr_merge = old;
      for (b = 0; b < 4; b = b + 1) begin
        if (strb[b]) begin
          asr_merge[b*8 +: 8] = wd[b*8 +: 8];
        end
      end
    end
  endfunction

  // interval code to period in clock cycles, rounded down
  // rounding down makes a period at most one clock short, never long
  // the longest code needs 20000 cycles, which fits the 15-bit counter
  function [14:0] asr_per_cyc;
    input [3:0] code;
    integer ns;
    integer q;
    begin
      ns = `ASR_PER_NS_0;
      case (code)
        4'h0: ns = `ASR_PER_NS_0;
        4'h1: ns = `ASR_PER_NS_1;
        4'h2: ns = `ASR_PER_NS_2;
        4'h3: ns = `ASR_PER_NS_3;
        4'h4: ns = `ASR_PER_NS_4;
        4'h5: ns = `ASR_PER_NS_5;
        4'h6: ns = `ASR_PER_NS_6;
        4'h7: ns = `ASR_PER_NS_7;
        4'h8: ns = `ASR_PER_NS_8;
        4'h9: ns = `ASR_PER_NS_9;
        4'ha: ns = `ASR_PER_NS_A;
        4'hb: ns = `ASR_PER_NS_B;
        4'hc: ns = `ASR_PER_NS_C;
        4'hd: ns = `ASR_PER_NS_D;
        4'he: ns = `ASR_PER_NS_E;
        default: ns = `ASR_PER_NS_F;
      endcase
      q = ns / `ASR_CLK_NS;
      asr_per_cyc = q[14:0];
    end
  endfunction

  // ------------------------------------------------------------
  // apb decode
  // ------------------------------------------------------------

  // register index from the word address; the low two bits must be zero
  wire [9:0] idx = paddr[11:2];
  wire aligned = (paddr[1:0] == 2'b00);
  wire hit_cell = aligned && (idx == `ASR_IDX_CELL);
  wire hit_aux = aligned && (idx == `ASR_IDX_AUX);
  wire hit_test = aligned && (idx == `ASR_IDX_TEST);
  wire hit_shdn = aligned && (idx == `ASR_IDX_SHDN);
  wire hit_ists = aligned && (idx == `ASR_IDX_IRQ_STS);
  wire hit_imsk = aligned && (idx == `ASR_IDX_IRQ_MSK);
  wire hit_ctrl = aligned && (idx == `ASR_IDX_CTRL);
  wire hit_live = aligned && (idx == `ASR_IDX_LIVE);
  wire hit_any = hit_cell | hit_aux | hit_test | hit_shdn | hit_ists | hit_imsk | hit_ctrl | hit_live;

  // zero wait states: every access completes in its first access cycle
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~hit_any;

  // access qualifiers; reads are taken one cycle early, in setup
  wire acc = psel & penable;
  wire wr = acc & pwrite;
  wire setup_rd = psel & ~penable & ~pwrite;

  // ------------------------------------------------------------
  // interval registers
  // ------------------------------------------------------------

  // interval storage; only the lanes named by pstrb change
  reg [7:0] cell_q;
  reg [31:0] aux_q;
  reg [15:0] test_q;
  wire [31:0] cell_m = asr_merge({24'h000000, cell_q}, pwdata, pstrb);
  wire [31:0] aux_m = asr_merge(aux_q, pwdata, pstrb);
  wire [31:0] test_m = asr_merge({16'h0000, test_q}, pwdata, pstrb);

  // reserved nibble of the test register is stored as written so it reads back
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cell_q <= `ASR_RST_CELL;
      aux_q <= `ASR_RST_AUX;
      test_q <= `ASR_RST_TEST;
    end else if (wr) begin
      if (hit_cell) begin
        cell_q <= cell_m[7:0];
      end
      if (hit_aux) begin
        aux_q <= aux_m;
      end
      if (hit_test) begin
        test_q <= test_m[15:0];
      end
    end
  end

  // field breakout toward the conversion sequencer
  assign cell_interval_code = cell_q[7:4];
  assign die_temp_interval_code = cell_q[3:0];
  assign sensor_input0_interval = aux_q[31:28];
  assign sensor_input1_interval = aux_q[27:24];
  assign sensor_input2_interval = aux_q[23:20];
  assign sensor_input3_interval = aux_q[19:16];
  assign sensor_input4_interval = aux_q[15:12];
  assign sensor_input5_interval = aux_q[11:8];
  assign sensor_input6_interval = aux_q[7:4];
  assign sensor_input7_interval = aux_q[3:0];
  assign module_monitor_interval = test_q[15:12];
  assign analog_ref_interval = test_q[7:4];
  assign negative_rail_interval = test_q[3:0];

  // channel order: cell, die temp, aux 0..7, module, reference, negative rail
  wire [NCH*4-1:0] codes = {cell_q, aux_q, test_q[15:12], test_q[7:0]};

  // ------------------------------------------------------------
  // control register
  // ------------------------------------------------------------

  // control state: sample enable and the one-cycle power-down pulse
  reg sample_en_q;
  reg pd_pulse_q;
  wire pd_write = wr & hit_ctrl & pstrb[0] & pwdata[`ASR_CTRL_PD];

  // power-down bit is a trigger: it gives one pulse and reads back zero
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sample_en_q <= 1'b0;
      pd_pulse_q <= 1'b0;
    end else begin
      pd_pulse_q <= pd_write;
      if (wr & hit_ctrl & pstrb[0]) begin
        sample_en_q <= pwdata[`ASR_CTRL_SEN];
      end
    end
  end

  // registered so the pulse cannot glitch on a decode hazard
  assign power_down_request = pd_pulse_q;

  // ------------------------------------------------------------
  // event input synchronisers
  // ------------------------------------------------------------

  // event inputs come from other domains; bit order matches the live register
  wire [6:0] ev_raw = {comm_pd_timeout, digital_tsd, io_supply_held_low, always_on_supply_por,
                       analog_pd_req, regulator_timeout, analog_tsd};
  wire [6:0] ev_lvl;
  wire [6:0] ev_rise;

  genvar g;
  generate
    for (g = 0; g < 7; g = g + 1) begin : g_sync
      reg s1_q;
      reg s2_q;
      reg s3_q;
      // first stage feeds only the second; edges are taken on later stages
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          s1_q <= 1'b0;
          s2_q <= 1'b0;
          s3_q <= 1'b0;
        end else begin
          s1_q <= ev_raw[g];
          s2_q <= s1_q;
          s3_q <= s2_q;
        end
      end
      // a level held high gives one event; a new event needs a fresh rise
      assign ev_lvl[g] = s2_q;
      assign ev_rise[g] = s2_q & ~s3_q;
    end
  endgenerate

  // ------------------------------------------------------------
  // shutdown cause record
  // ------------------------------------------------------------

  // cause record and its per-cycle set vector
  reg [7:0] sd_q;
  wire [7:0] sd_set;

  // map events onto cause bits; bits 3:2 have no source
  assign sd_set[`ASR_SD_CTRL] = pd_write | ev_rise[6];
  assign sd_set[`ASR_SD_DIGT] = ev_rise[5] | ev_rise[4];
  assign sd_set[`ASR_SD_AON] = ev_rise[3];
  assign sd_set[`ASR_SD_ANA] = ev_rise[2];
  assign sd_set[3:2] = 2'b00;
  assign sd_set[`ASR_SD_REG] = ev_rise[1];
  assign sd_set[`ASR_SD_ANT] = ev_rise[0];

  // sticky until reset; bus writes never clear it, so debug history survives
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sd_q <= 8'h00;
    end else begin
      sd_q <= (sd_q | sd_set) & `ASR_SD_RSVD_MASK;
    end
  end

  // validity of bits 1:0 is left to the reader
  assign shutdown_cause = sd_q;

  // ------------------------------------------------------------
  // interrupt status and mask
  // ------------------------------------------------------------

  // status mirrors the cause layout; the mask uses the same bits
  reg [7:0] ists_q;
  reg [7:0] imsk_q;
  wire [7:0] iclr = (wr & hit_ists & pstrb[0]) ? pwdata[7:0] : 8'h00;

  // write one to clear; an event in the same cycle keeps its bit set
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ists_q <= 8'h00;
      imsk_q <= 8'h00;
    end else begin
      ists_q <= ((ists_q & ~iclr) | sd_set) & `ASR_SD_RSVD_MASK;
      if (wr & hit_imsk & pstrb[0]) begin
        imsk_q <= pwdata[7:0] & `ASR_SD_RSVD_MASK;
      end
    end
  end

  // level output: high until software clears or masks the bit
  assign irq = |(ists_q & imsk_q);

  // ------------------------------------------------------------
  // per-channel sample tick generators
  // ------------------------------------------------------------

  // one flag per channel for codes below the analog accuracy limit
  wire [NCH-1:0] low_code;

  generate
    for (g = 0; g < NCH; g = g + 1) begin : g_tick
      wire [3:0] code = codes[(NCH-1-g)*4 +: 4];
      reg [14:0] cnt_q;
      reg tick_q;
      // reload from the current code so a new setting applies from the next period
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          cnt_q <= 15'h0000;
          tick_q <= 1'b0;
        end else if (!sample_en_q) begin
          cnt_q <= 15'h0000;
          tick_q <= 1'b0;
        end else begin
          tick_q <= (cnt_q == 15'h0000);
          if (cnt_q == 15'h0000) begin
            cnt_q <= asr_per_cyc(code) - 15'h0001;
          end else begin
            cnt_q <= cnt_q - 15'h0001;
          end
        end
      end
      assign sample_tick[g] = tick_q;
      // short codes are allowed but flagged, they degrade analog accuracy
      assign low_code[g] = (code < `ASR_LOW_CODE_LIMIT);
    end
  endgenerate

  // ------------------------------------------------------------
  // read mux and read data register
  // ------------------------------------------------------------

  // read selection; at most one hit is active for an aligned address
  reg [31:0] rd_mux;

  // unmapped addresses read zero besides raising the error
  always @* begin
    rd_mux = 32'h00000000;
    case (1'b1)
      hit_cell: rd_mux = {24'h000000, cell_q};
      hit_aux: rd_mux = aux_q;
      hit_test: rd_mux = {16'h0000, test_q};
      hit_shdn: rd_mux = {24'h000000, sd_q};
      hit_ists: rd_mux = {24'h000000, ists_q};
      hit_imsk: rd_mux = {24'h000000, imsk_q};
      hit_ctrl: rd_mux = {30'h00000000, sample_en_q, 1'b0};
      hit_live: rd_mux = {9'h000, ev_lvl, 3'h0, low_code};
      default: rd_mux = 32'h00000000;
    endcase
  end

  // captured in the setup cycle so prdata comes straight from a flop
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (setup_rd) begin
      prdata <= rd_mux;
    end
  end

endmodule // asr_interval_shutdown
`default_nettype wire

// File: rtl/asr_regs.vh
// register map, reset values and timing figures of the adc interval and shutdown register bank
`ifndef ASR_REGS_VH
`define ASR_REGS_VH

// ------------------------------------------------------------
// register indices (byte address is four times the index)
// ------------------------------------------------------------
`define ASR_IDX_CELL 10'h03e
`define ASR_IDX_AUX 10'h03f
`define ASR_IDX_TEST 10'h043
`define ASR_IDX_SHDN 10'h050
`define ASR_IDX_IRQ_STS 10'h060
`define ASR_IDX_IRQ_MSK 10'h061
`define ASR_IDX_CTRL 10'h062
`define ASR_IDX_LIVE 10'h063

// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define ASR_SD_CTRL 7
`define ASR_SD_DIGT 6
`define ASR_SD_AON 5
`define ASR_SD_ANA 4
`define ASR_SD_REG 1
`define ASR_SD_ANT 0
`define ASR_SD_RSVD_MASK 8'hf3
`define ASR_CTRL_PD 0
`define ASR_CTRL_SEN 1
`define ASR_TEST_RSVD_VAL 4'h9
`define ASR_LOW_CODE_LIMIT 4'h4

// ------------------------------------------------------------
// reset values
// ------------------------------------------------------------
`define ASR_RST_CELL 8'h88
`define ASR_RST_AUX 32'h88888888
`define ASR_RST_TEST 16'h8988

// ------------------------------------------------------------
// timing: clock period and sampling periods in ns
// ------------------------------------------------------------
`define ASR_CLK_NS 50
`define ASR_PER_NS_0 4130
`define ASR_PER_NS_1 5960
`define ASR_PER_NS_2 8020
`define ASR_PER_NS_3 10000
`define ASR_PER_NS_4 12600
`define ASR_PER_NS_5 14900
`define ASR_PER_NS_6 17400
`define ASR_PER_NS_7 19900
`define ASR_PER_NS_8 24900
`define ASR_PER_NS_9 30000
`define ASR_PER_NS_A 40100
`define ASR_PER_NS_B 60000
`define ASR_PER_NS_C 100000
`define ASR_PER_NS_D 200000
`define ASR_PER_NS_E 500000
`define ASR_PER_NS_F 1000000

`endif

// File: bench/asr_interval_shutdown_monitor.sv
// port-level checker for the interval and shutdown register bank
`timescale 1ns/1ps
`default_nettype none
module asr_interval_shutdown_monitor #(
  parameter NCH = 13
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic power_down_request,
  input wire logic analog_tsd,
  input wire logic [3:0] cell_interval_code,
  input wire logic [7:0] shutdown_cause,
  input wire logic [NCH-1:0] sample_tick
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ------------------------------------------------------------
  // bus steps
  // ------------------------------------------------------------
  sequence s_pd_write;
    psel && penable && pwrite && paddr == 12'h188 && pstrb[0] && pwdata[0];
  endsequence
  // only analog_tsd is required low; the other event inputs can still move the record
  sequence s_cause_write;
    psel && penable && pwrite && paddr == 12'h140 && !analog_tsd;
  endsequence
  a_rsvd_read_zero: assert property (shutdown_cause[3:2] == 2'b00)
    else $error("reserved cause bits set");
  a_cause_ro_write: assert property (s_cause_write |=> shutdown_cause == $past(shutdown_cause))
    else $error("write changed shutdown cause");
  a_pd_sets_flag: assert property (s_pd_write |=> shutdown_cause[7])
    else $error("controller flag not set");
  a_pd_pulse_follows: assert property (s_pd_write |-> ##[1:2] power_down_request)
    else $error("no power-down pulse");
  a_pd_pulse_width: assert property (power_down_request |=> !power_down_request)
    else $error("power-down pulse too long");
  a_analog_tsd_flag: assert property ($rose(analog_tsd) |-> ##[2:4] shutdown_cause[0])
    else $error("analog thermal flag late");
  a_cause_sticky_bits: assert property (##1 (($past(shutdown_cause) & ~shutdown_cause) == 8'h00))
    else $error("cause bit cleared");
  a_codes_hold: assert property (!(psel && penable && pwrite) |=> $stable(cell_interval_code))
    else $error("cell code moved without write");
  a_slverr_access: assert property (pslverr |-> psel && penable)
    else $error("error outside access");
  a_ready_zero_wait: assert property (psel && penable |-> pready)
    else $error("access not ready");
  a_tick_single: assert property (sample_tick[0] |=> !sample_tick[0])
    else $error("cell tick too long");
endmodule // asr_interval_shutdown_monitor

bind asr_interval_shutdown asr_interval_shutdown_monitor #(.NCH(NCH)) i_mon (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
  .pready(pready), .pslverr(pslverr), .power_down_request(power_down_request), .analog_tsd(analog_tsd),
  .cell_interval_code(cell_interval_code), .shutdown_cause(shutdown_cause), .sample_tick(sample_tick));
`default_nettype wire

// File: bench/asr_interval_shutdown_tb_top.sv
// self-checking bench for the interval and shutdown register bank
`timescale 1ns/1ps
`default_nettype none
`include "asr_regs.vh"
module asr_interval_shutdown_tb_top;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, irq, pdr, er;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [3:0] pstrb = 4'hf, cc, dc, a0, a1, a2, a3, a4, a5, a6, a7, mm, ar, nr;
  logic [6:0] ev = 7'h00;
  logic [7:0] sc;
  logic [12:0] tk;
  int fail_count = 0, n_compared = 0, cyc = 0;
  int per[16] = '{82, 119, 160, 200, 252, 298, 348, 398, 498, 600, 802, 1200, 2000, 4000, 10000, 20000};
  int bm[7] = '{0, 1, 4, 5, 6, 6, 7};
  always #25 pclk = ~pclk;
  asr_interval_shutdown i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .irq(irq), .comm_pd_timeout(ev[6]), .digital_tsd(ev[5]), .io_supply_held_low(ev[4]),
    .always_on_supply_por(ev[3]), .analog_pd_req(ev[2]), .regulator_timeout(ev[1]), .analog_tsd(ev[0]),
    .power_down_request(pdr), .cell_interval_code(cc), .die_temp_interval_code(dc), .sensor_input0_interval(a0),
    .sensor_input1_interval(a1), .sensor_input2_interval(a2), .sensor_input3_interval(a3),
    .sensor_input4_interval(a4), .sensor_input5_interval(a5), .sensor_input6_interval(a6),
    .sensor_input7_interval(a7), .module_monitor_interval(mm), .analog_ref_interval(ar),
    .negative_rail_interval(nr), .shutdown_cause(sc), .sample_tick(tk));
  // ------------------------------------------------------------
  // shared tasks
  // ------------------------------------------------------------
  task automatic complete_run;
    $display("counts: %0d compared, %0d mismatched", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      fail_count++;
      $display("[FAIL] %0t got %h expected %h", $time, g, e);
    end
  endtask
  // one apb transfer; waits for pready, takes data and error at that edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rst;
    presetn <= 1'b0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
  endtask
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_reset_vals;
    apb(0, 12'h0f8, 0);
    chk(rd, `ASR_RST_CELL);
    apb(0, 12'h0fc, 0);
    chk(rd, `ASR_RST_AUX);
    apb(0, 12'h10c, 0);
    chk(rd, `ASR_RST_TEST);
    apb(0, 12'h140, 0);
    chk(rd, 0);
    $display("test reset_values done");
  endtask
  // distinct nibbles catch swapped or shifted fields
  task automatic t_fields;
    apb(1, 12'h0f8, 32'h5a);
    apb(1, 12'h0fc, 32'h01234567);
    apb(1, 12'h10c, 32'hc9e1);
    @(posedge pclk);
    chk({cc, dc}, 8'h5a);
    chk({a0, a1, a2, a3, a4, a5, a6, a7}, 32'h01234567);
    chk({mm, ar, nr}, 12'hce1);
    apb(0, 12'h10c, 0);
    chk(rd, 32'hc9e1);
    $display("test fields done");
  endtask
  task automatic t_refuse;
    apb(0, 12'h200, 0);
    chk(er, 1);
    chk(rd, 0);
    apb(1, 12'h0f9, 32'hff);
    chk(er, 1);
    apb(1, 12'h140, 32'hff);
    chk(er, 0);
    apb(0, 12'h0f8, 0);
    chk(rd, 32'h5a);
    apb(0, 12'h140, 0);
    chk(rd, 0);
    $display("test refusals done");
  endtask
  task automatic t_pd;
    int n;
    n = 0;
    apb(1, 12'h188, 1);
    repeat (4) begin
      @(posedge pclk);
      n += pdr;
    end
    chk(n, 1);
    apb(0, 12'h140, 0);
    chk(rd, 32'h80);
    $display("test power_down done");
  endtask
  // each event in turn: live level while held, record accumulates, status bit alone then cleared
  task automatic t_events;
    logic [31:0] exp;
    exp = 0;
    rst;
    for (int i = 0; i < 7; i++) begin
      @(posedge pclk);
      ev <= 7'h01 << i;
      repeat (6) @(posedge pclk);
      apb(0, 12'h18c, 0);
      chk(rd, 32'h1 << (16 + i));
      ev <= 7'h00;
      exp |= 32'h1 << bm[i];
      apb(0, 12'h140, 0);
      chk(rd, exp);
      apb(0, 12'h180, 0);
      chk(rd, 32'h1 << bm[i]);
      apb(1, 12'h180, 32'hff);
    end
    chk(irq, 0);
    apb(1, 12'h184, 32'hff);
    @(posedge pclk);
    chk(irq, 0);
    apb(0, 12'h184, 0);
    chk(rd, 32'hf3);
    apb(1, 12'h188, 32'h1);
    @(posedge pclk);
    chk(irq, 1);
    apb(0, 12'h180, 0);
    chk(rd, 32'h80);
    apb(1, 12'h180, 32'hff);
    @(posedge pclk);
    chk(irq, 0);
    apb(0, 12'h140, 0);
    chk(rd, 32'hf3);
    // bits 1:0 are only trusted once the analog flag is seen
    if (rd[`ASR_SD_ANA]) begin
      chk(rd[1:0], 2'b11);
    end
    $display("test events done");
  endtask
  // every code: cycles between two cell ticks
  task automatic t_periods;
    int n;
    for (int c = 0; c < 16; c++) begin
      apb(1, 12'h188, 0);
      apb(1, 12'h0f8, {24'h0, c[3:0], 4'h8});
      apb(0, 12'h18c, 0);
      chk(rd, {31'h0, c < 4});
      apb(1, 12'h188, 2);
      while (tk[0] !== 1'b1) @(posedge pclk);
      chk(tk, 13'h1fff);
      n = 0;
      do begin
        @(posedge pclk);
        n++;
      end while (tk[0] !== 1'b1);
      chk(n, per[c]);
    end
    $display("test periods done");
  endtask
  // cycle ceiling well above the longest expected run
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 70000) begin
      fail_count++;
      $display("[FAIL] %0t timeout", $time);
      complete_run;
    end
  end
  initial begin
    rst;
    t_reset_vals;
    t_fields;
    t_refuse;
    t_pd;
    t_events;
    t_periods;
    complete_run;
  end
endmodule // asr_interval_shutdown_tb_top
`default_nettype wire
